/* File: rtl/dtpu_pkg.sv */
/*
 * Types shared by the down-timer PWM unit: bus request, pin carrier,
 * timer state and the per-module state records.
 * Assumes dtpu_regs.svh is on the include path.
 */
`include "dtpu_regs.svh"

package dtpu_pkg;

    typedef struct packed {
        logic [`DTPU_AW-1:0] addr;
        logic [`DTPU_DW-1:0] wdata;
        logic wr;
        logic rd;
    } dtpu_bus_t;

    // level is the waveform, sel hands the pin to the PWM instead of GPIO
    typedef struct packed {
        logic level;
        logic sel;
    } dtpu_pin_t;

    typedef enum logic [1:0] {
        DTPU_T4_COUNT = 2'b01,
        DTPU_T4_DONE = 2'b10
    } dtpu_t4_state_t;

    typedef struct packed {
        logic [`DTPU_PSW-1:0] cnt;
        logic tick;
    } dtpu_ps_state_t;

    typedef struct packed {
        logic [7:0] t1_rl_lo;
        logic [7:0] t1_hi;
        logic [`DTPU_TW-1:0] t1_cnt;
        logic [7:0] p2_ctl;
        logic [7:0] p2_duty;
        logic [7:0] p3_ctl;
        logic [7:0] p3_duty;
        logic [7:0] sh_hi;
        logic [7:0] t4_rl_lo;
        logic [7:0] t4_ctl1;
        logic [7:0] t4_ctl2;
        logic [7:0] p4_duty;
        logic [`DTPU_TW-1:0] t4_cnt;
        dtpu_t4_state_t t4_state;
        logic flag;
        logic [`DTPU_DW-1:0] rdata;
        logic [2:0] ext;
    } dtpu_top_state_t;

endpackage

/* File: rtl/dtpu_prescaler.sv */
/*
 * Power-of-two prescaler for the fourth timer, with bypass.
 * Assumes i_src_tick is a one-cycle enable on i_clk.
 */
`timescale 1ns/1ps
`include "dtpu_regs.svh"

module dtpu_prescaler #(
    parameter int W = `DTPU_PSW
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // control
    input wire logic i_src_tick,
    input wire logic i_disable_n,
    input wire logic [2:0] i_ratio,
    // divided tick
    output logic o_tick
);
    dtpu_pkg::dtpu_ps_state_t r;
    dtpu_pkg::dtpu_ps_state_t next_r;
    logic [W-1:0] mask;

    // code 0 divides by 2, code 7 by 256
    assign mask = ~({W{1'b1}} << (4'(i_ratio) + 4'h1));

    always_comb
    begin
        next_r = r;
        next_r.tick = 1'b0;
        if (i_disable_n)
        begin
            next_r.cnt = '0;
            next_r.tick = i_src_tick;
        end
        else if (i_src_tick)
        begin
            if ((r.cnt & mask) == mask)
            begin
                next_r.cnt = '0;
                next_r.tick = 1'b1;
            end
            else
            begin
                next_r.cnt = r.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            r <= '0;
        else
            r <= next_r;
    end

    assign o_tick = r.tick;
endmodule // dtpu_prescaler

/* File: rtl/dtpu_pwm_out.sv */
/*
 * One PWM channel output stage: compare, polarity, pin ownership.
 * Assumes count and duty come from logic on i_clk.
 */
`timescale 1ns/1ps
`include "dtpu_regs.svh"

module dtpu_pwm_out #(
    parameter int CW = `DTPU_TW
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // channel setup
    input wire logic [CW-1:0] i_count,
    input wire logic [CW-1:0] i_duty,
    input wire logic i_polarity,
    input wire logic i_enable,
    // pin
    output dtpu_pkg::dtpu_pin_t o_pin
);
    dtpu_pkg::dtpu_pin_t r;
    dtpu_pkg::dtpu_pin_t next_r;

    always_comb
    begin
        next_r = r;
        // active while the down count sits below the duty value
        next_r.level = (i_count < i_duty) ^ i_polarity;
        next_r.sel = i_enable;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            r <= '0;
        else
            r <= next_r;
    end

    assign o_pin = r;
endmodule // dtpu_pwm_out

/* File: rtl/dtpu_regs.svh */
/*
 * Register offsets, field positions, reset values and fixed counts
 * of the down-timer PWM unit.
 * Assumes it is included by its bare name wherever a number is needed.
 */
`ifndef DTPU_REGS_SVH
`define DTPU_REGS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define DTPU_AW 8
`define DTPU_DW 8
`define DTPU_TW 10
`define DTPU_PSW 8

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DTPU_ADDR_T1_COUNT 8'h02
`define DTPU_ADDR_T1_HIGH 8'h03
`define DTPU_ADDR_P2_CTL 8'h0A
`define DTPU_ADDR_P2_DUTY 8'h0C
`define DTPU_ADDR_P3_CTL 8'h11
`define DTPU_ADDR_P3_DUTY 8'h13
`define DTPU_ADDR_SH_HIGH 8'h14
`define DTPU_ADDR_T4_COUNT 8'h15
`define DTPU_ADDR_T4_CTL1 8'h16
`define DTPU_ADDR_T4_CTL2 8'h17
`define DTPU_ADDR_P4_DUTY 8'h18
`define DTPU_ADDR_STATUS 8'h20

// ----------------------------------------------------------------
// field positions (two-bit fields give their upper bit)
// ----------------------------------------------------------------
`define DTPU_OEN_BIT 7
`define DTPU_POL_BIT 6
`define DTPU_HRC_BIT 3
`define DTPU_OS_BIT 2
`define DTPU_RL_BIT 1
`define DTPU_EN_BIT 0
`define DTPU_CS_BIT 5
`define DTPU_CE_BIT 4
`define DTPU_PSDN_BIT 3
`define DTPU_PSSEL_MSB 2
`define DTPU_T1H_RL_MSB 5
`define DTPU_T1H_P2_MSB 3
`define DTPU_SH_T4_MSB 7
`define DTPU_SH_P4_MSB 3
`define DTPU_SH_P3_MSB 1
`define DTPU_FLAG_BIT 0

// ----------------------------------------------------------------
// implemented-bit masks and reset values
// ----------------------------------------------------------------
`define DTPU_PCTL_MASK 8'hC0
`define DTPU_CTL1_MASK 8'hCF
`define DTPU_CTL2_MASK 8'h3F
`define DTPU_T1H_MASK 8'h3C
`define DTPU_SH_MASK 8'hCF
`define DTPU_CTL2_RST 8'h3F
`define DTPU_ZERO8 8'h00
`define DTPU_ZERO10 10'h000
`define DTPU_T4_MAX 10'h3FF

`endif

/* File: rtl/dtpu_top.sv */
/*
 * Down-timer PWM unit: first (frame) timer, fourth down timer with
 * prescaler and clock selection, and three PWM channels.
 * Assumes i_inst_en and i_hosc_en are one-cycle enables on i_clk and
 * that i_external_count_pin is asynchronous.
 */
// Notes on behaviour
// - channel two: frame from first timer reload, duty from high bits 3:2 and duty byte
// - channel three: frame from first timer reload, duty from shared bits 1:0 and byte
// - channel three output is active low when its polarity bit is set
// - channel three enable hands its two pins to the PWM, else GPIO
// - reading the fourth count register returns the low count byte
// - writing it loads the counter from reload, top bits from shared 7:6
// - fourth timer counts only while its run bit is set
// - non-stop without reload select: continue from 0x3FF after underflow
// - non-stop with reload select: reload programmed value after underflow
// - one-shot: count once down to 0x00, then stop
// - fast clock select picks the high oscillator, else source bit decides
// - source bit set picks the external pin, else instruction clock
// - external edge bit picks falling edges when set, rising when clear
// - three-bit ratio divides by 2 up to 256
// - prescaler works only while its active-low enable bit is 0
// - channel four: frame from fourth reload (0x3FF without reload select), duty from shared bits 3:2 and byte
// - channel four output is active low when its polarity bit is set
// - channel four enable hands its pin to the PWM, else GPIO
// - channel two enable hands its two pins to the PWM, else GPIO
`timescale 1ns/1ps
`include "dtpu_regs.svh"

module dtpu_top (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register port
    input wire dtpu_pkg::dtpu_bus_t i_bus,
    output logic [`DTPU_DW-1:0] o_rdata,
    // clock sources
    input wire logic i_inst_en,
    input wire logic i_hosc_en,
    input wire logic i_external_count_pin,
    // pins
    output dtpu_pkg::dtpu_pin_t o_port_a_pin_four,
    output dtpu_pkg::dtpu_pin_t o_port_b_pin_five,
    output dtpu_pkg::dtpu_pin_t o_port_a_pin_two,
    output dtpu_pkg::dtpu_pin_t o_port_a_pin_seven,
    output dtpu_pkg::dtpu_pin_t o_port_b_pin_three,
    // status
    output logic o_timer4_event
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    dtpu_pkg::dtpu_top_state_t r;
    dtpu_pkg::dtpu_top_state_t next_r;

    logic ext_rise;
    logic ext_fall;
    logic ext_tick;
    logic src_tick;
    logic t4_tick;
    logic [`DTPU_TW-1:0] t1_reload;
    logic [`DTPU_TW-1:0] t4_reload;
    logic [`DTPU_TW-1:0] t4_loaded;
    logic t4_wr;
    logic stat_wr;

    // ----------------------------------------------------------------
    // clock selection
    // ----------------------------------------------------------------
    // ext[0] is the first synchroniser stage and feeds only ext[1]
    assign ext_rise = r.ext[1] & ~r.ext[2];
    assign ext_fall = ~r.ext[1] & r.ext[2];

    always_comb
    begin
        if (r.t4_ctl2[`DTPU_CE_BIT])
            ext_tick = ext_fall;
        else
            ext_tick = ext_rise;
    end

    always_comb
    begin
        if (r.t4_ctl1[`DTPU_HRC_BIT])
            src_tick = i_hosc_en;
        else if (r.t4_ctl2[`DTPU_CS_BIT])
            src_tick = ext_tick;
        else
            src_tick = i_inst_en;
    end

    // with the high oscillator selected the prescaler is expected off;
    // nothing here forces it, so a wrong setting just divides that clock
    dtpu_prescaler #(
        .W(`DTPU_PSW)
    ) u_prescaler (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_src_tick(src_tick),
        .i_disable_n(r.t4_ctl2[`DTPU_PSDN_BIT]),
        .i_ratio(r.t4_ctl2[`DTPU_PSSEL_MSB:0]),
        .o_tick(t4_tick)
    );

    // ----------------------------------------------------------------
    // reload values
    // ----------------------------------------------------------------
    assign t1_reload = {r.t1_hi[`DTPU_T1H_RL_MSB -: 2], r.t1_rl_lo};
    assign t4_reload = {r.sh_hi[`DTPU_SH_T4_MSB -: 2], r.t4_rl_lo};
    assign t4_loaded = {r.sh_hi[`DTPU_SH_T4_MSB -: 2], i_bus.wdata};

    assign t4_wr = i_bus.wr && (i_bus.addr == `DTPU_ADDR_T4_COUNT);
    assign stat_wr = i_bus.wr && (i_bus.addr == `DTPU_ADDR_STATUS);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        next_r.ext = {r.ext[1:0], i_external_count_pin};
        next_r.rdata = `DTPU_ZERO8;

        // first timer: free-running frame base on the instruction clock
        if (i_inst_en)
        begin
            if (r.t1_cnt == `DTPU_ZERO10)
                next_r.t1_cnt = t1_reload;
            else
                next_r.t1_cnt = r.t1_cnt - `DTPU_TW'(1);
        end

        // fourth timer
        case (r.t4_state)
            dtpu_pkg::DTPU_T4_COUNT:
            begin
                if (t4_tick && r.t4_ctl1[`DTPU_EN_BIT])
                begin
                    if (r.t4_cnt == `DTPU_ZERO10)
                    begin
                        if (r.t4_ctl1[`DTPU_OS_BIT])
                            next_r.t4_state = dtpu_pkg::DTPU_T4_DONE;
                        else if (r.t4_ctl1[`DTPU_RL_BIT])
                            next_r.t4_cnt = t4_reload;
                        else
                            next_r.t4_cnt = `DTPU_T4_MAX;
                    end
                    else
                    begin
                        next_r.t4_cnt = r.t4_cnt - `DTPU_TW'(1);
                    end
                end
            end
            dtpu_pkg::DTPU_T4_DONE:
            begin
                // held at zero until re-armed by a load or by leaving one-shot
                if (!r.t4_ctl1[`DTPU_OS_BIT])
                    next_r.t4_state = dtpu_pkg::DTPU_T4_COUNT;
            end
            default:
            begin
                next_r.t4_state = dtpu_pkg::DTPU_T4_COUNT;
            end
        endcase

        // ------------------------------------------------------------
        // register writes; a count load overrides the tick
        // ------------------------------------------------------------
        if (i_bus.wr)
        begin
            case (i_bus.addr)
                `DTPU_ADDR_T1_COUNT:
                begin
                    next_r.t1_rl_lo = i_bus.wdata;
                    next_r.t1_cnt = {r.t1_hi[`DTPU_T1H_RL_MSB -: 2], i_bus.wdata};
                end
                `DTPU_ADDR_T1_HIGH:
                begin
                    next_r.t1_hi = i_bus.wdata & `DTPU_T1H_MASK;
                end
                `DTPU_ADDR_P2_CTL:
                begin
                    next_r.p2_ctl = i_bus.wdata & `DTPU_PCTL_MASK;
                end
                `DTPU_ADDR_P2_DUTY:
                begin
                    next_r.p2_duty = i_bus.wdata;
                end
                `DTPU_ADDR_P3_CTL:
                begin
                    next_r.p3_ctl = i_bus.wdata & `DTPU_PCTL_MASK;
                end
                `DTPU_ADDR_P3_DUTY:
                begin
                    next_r.p3_duty = i_bus.wdata;
                end
                `DTPU_ADDR_SH_HIGH:
                begin
                    next_r.sh_hi = i_bus.wdata & `DTPU_SH_MASK;
                end
                `DTPU_ADDR_T4_COUNT:
                begin
                    next_r.t4_rl_lo = i_bus.wdata;
                    next_r.t4_cnt = t4_loaded;
                    next_r.t4_state = dtpu_pkg::DTPU_T4_COUNT;
                end
                `DTPU_ADDR_T4_CTL1:
                begin
                    next_r.t4_ctl1 = i_bus.wdata & `DTPU_CTL1_MASK;
                end
                `DTPU_ADDR_T4_CTL2:
                begin
                    next_r.t4_ctl2 = i_bus.wdata & `DTPU_CTL2_MASK;
                end
                `DTPU_ADDR_P4_DUTY:
                begin
                    next_r.p4_duty = i_bus.wdata;
                end
                default:
                begin
                end
            endcase
        end

        // ------------------------------------------------------------
        // event flag: write one to clear, a same-cycle underflow wins
        // ------------------------------------------------------------
        if (stat_wr && i_bus.wdata[`DTPU_FLAG_BIT])
            next_r.flag = 1'b0;
        if (t4_tick && r.t4_ctl1[`DTPU_EN_BIT] && !t4_wr
            && (r.t4_state == dtpu_pkg::DTPU_T4_COUNT)
            && (r.t4_cnt == `DTPU_ZERO10))
            next_r.flag = 1'b1;

        // ------------------------------------------------------------
        // register reads, data in the following cycle
        // ------------------------------------------------------------
        if (i_bus.rd)
        begin
            case (i_bus.addr)
                `DTPU_ADDR_T1_COUNT:
                begin
                    next_r.rdata = r.t1_cnt[7:0];
                end
                `DTPU_ADDR_T1_HIGH:
                begin
                    next_r.rdata = r.t1_hi;
                end
                `DTPU_ADDR_P2_CTL:
                begin
                    next_r.rdata = r.p2_ctl;
                end
                `DTPU_ADDR_P3_CTL:
                begin
                    next_r.rdata = r.p3_ctl;
                end
                `DTPU_ADDR_SH_HIGH:
                begin
                    next_r.rdata = r.sh_hi;
                end
                `DTPU_ADDR_T4_COUNT:
                begin
                    next_r.rdata = r.t4_cnt[7:0];
                end
                `DTPU_ADDR_T4_CTL1:
                begin
                    next_r.rdata = r.t4_ctl1;
                end
                `DTPU_ADDR_T4_CTL2:
                begin
                    next_r.rdata = r.t4_ctl2;
                end
                `DTPU_ADDR_STATUS:
                begin
                    next_r.rdata = {7'h00, r.flag};
                end
                default:
                begin
                    // duty bytes are write-only; unmapped reads give zero
                    next_r.rdata = `DTPU_ZERO8;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            r <= '0;
            r.t4_ctl2 <= `DTPU_CTL2_RST;
            r.t4_state <= dtpu_pkg::DTPU_T4_COUNT;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // PWM channels: 0 = second, 1 = third, 2 = fourth
    // ----------------------------------------------------------------
    logic [`DTPU_TW-1:0] ch_count [3];
    logic [`DTPU_TW-1:0] ch_duty [3];
    logic ch_pol [3];
    logic ch_en [3];
    dtpu_pkg::dtpu_pin_t ch_pin [3];

    // frame length follows the value each timer counts from: its reload, or 0x3FF for the fourth without reload select
    assign ch_count[0] = r.t1_cnt;
    assign ch_duty[0] = {r.t1_hi[`DTPU_T1H_P2_MSB -: 2], r.p2_duty};
    assign ch_pol[0] = r.p2_ctl[`DTPU_POL_BIT];
    assign ch_en[0] = r.p2_ctl[`DTPU_OEN_BIT];

    assign ch_count[1] = r.t1_cnt;
    assign ch_duty[1] = {r.sh_hi[`DTPU_SH_P3_MSB -: 2], r.p3_duty};
    assign ch_pol[1] = r.p3_ctl[`DTPU_POL_BIT];
    assign ch_en[1] = r.p3_ctl[`DTPU_OEN_BIT];

    assign ch_count[2] = r.t4_cnt;
    assign ch_duty[2] = {r.sh_hi[`DTPU_SH_P4_MSB -: 2], r.p4_duty};
    assign ch_pol[2] = r.t4_ctl1[`DTPU_POL_BIT];
    assign ch_en[2] = r.t4_ctl1[`DTPU_OEN_BIT];

    for (genvar g = 0; g < 3; g++)
    begin : g_ch
        dtpu_pwm_out #(
            .CW(`DTPU_TW)
        ) u_pwm (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_count(ch_count[g]),
            .i_duty(ch_duty[g]),
            .i_polarity(ch_pol[g]),
            .i_enable(ch_en[g]),
            .o_pin(ch_pin[g])
        );
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_port_a_pin_four = ch_pin[0];
    assign o_port_b_pin_five = ch_pin[0];
    assign o_port_a_pin_two = ch_pin[1];
    assign o_port_a_pin_seven = ch_pin[1];
    assign o_port_b_pin_three = ch_pin[2];
    assign o_rdata = r.rdata;
    assign o_timer4_event = r.flag;
endmodule // dtpu_top

/* File: verification/down_timer_pwm_unit_test.sv */
/*
 * Self-checking bench for dtpu_top: registers, PWM pins, timer modes.
 * Assumes the rtl package, header and modules are compiled first.
 */
`timescale 1ns/1ps

module down_timer_pwm_unit_test;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    dtpu_pkg::dtpu_bus_t i_bus = '0;
    logic [7:0] o_rdata;
    logic i_inst_en = 1'b0;
    logic i_hosc_en = 1'b0;
    logic i_external_count_pin = 1'b0;
    dtpu_pkg::dtpu_pin_t o_port_a_pin_four, o_port_b_pin_five, o_port_a_pin_two;
    dtpu_pkg::dtpu_pin_t o_port_a_pin_seven, o_port_b_pin_three;
    logic o_timer4_event;
    logic [31:0] seed = 32'h3FEEE43A;
    logic [31:0] bits = 32'h0;
    logic [1:0] inst_mode = 2'b10;
    logic [7:0] q, v;
    int error_cnt = 0;
    int comparisons = 0;

    always #2.5 i_clk = ~i_clk;

    dtpu_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata), .i_inst_en(i_inst_en),
        .i_hosc_en(i_hosc_en), .i_external_count_pin(i_external_count_pin),
        .o_port_a_pin_four(o_port_a_pin_four), .o_port_b_pin_five(o_port_b_pin_five),
        .o_port_a_pin_two(o_port_a_pin_two), .o_port_a_pin_seven(o_port_a_pin_seven),
        .o_port_b_pin_three(o_port_b_pin_three), .o_timer4_event(o_timer4_event));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // pin {level, sel}: full duty is active, polarity flips it
    function automatic logic [1:0] pin_exp(input logic full, input logic pol, input logic en);
        return {full ^ pol, en};
    endfunction

    // instruction clock: random, steady high or off
    always @(posedge i_clk)
    begin
        bits <= rnd();
        i_inst_en <= inst_mode[1] ? bits[0] : inst_mode[0];
    end

    task automatic end_sim();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one-sided window: tick pipeline latency makes exact counts unknowable
    task automatic near(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] tol);
        check(8'(exp - got) <= tol ? exp : got, exp);
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        @(posedge i_clk);
        i_bus <= {a, d, w, !w};
        @(posedge i_clk);
        i_bus <= '0;
        #1 r = o_rdata;
    endtask

    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        @(posedge i_clk);
        i_bus <= {a, d, 2'b10};
        @(posedge i_clk);
        i_bus <= {a, d, 2'b01};
        @(posedge i_clk);
        i_bus <= '0;
        #1 r = o_rdata;
    endtask

    task automatic arm(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] load);
        bus(1'b1, 8'h17, c2 | 8'h08, q);
        bus(1'b1, 8'h17, c2, q);
        bus(1'b1, 8'h20, 8'h01, q);
        wr_rd(8'h15, load, q);
        check(q, load);
        bus(1'b1, 8'h16, c1, q);
    endtask

    task automatic take(output logic [7:0] cnt);
        bus(1'b1, 8'h16, 8'h00, q);
        bus(1'b0, 8'h15, 8'h00, cnt);
    endtask

    task automatic span(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] exp);
        arm(c1, c2, 8'hFF);
        repeat (128) @(posedge i_clk);
        take(v);
        near(8'hFF - v, exp + 8'h03, 8'h06);
        repeat (20) @(posedge i_clk);
        bus(1'b0, 8'h15, 8'h00, q);
        check(q, v);
    endtask

    task automatic mode_run(input logic [7:0] c1, input logic [7:0] load, input int idle, input logic [7:0] exp,
        input logic [7:0] tol);
        arm(c1, 8'h08, load);
        repeat (600) if (o_timer4_event !== 1'b1) @(negedge i_clk);
        repeat (idle) @(posedge i_clk);
        take(v);
        near(v, exp, tol);
        check(o_timer4_event, 1'b1);
        bus(1'b0, 8'h20, 8'h00, q);
        check(q, 8'h01);
        bus(1'b1, 8'h20, 8'h01, q);
        repeat (4) @(posedge i_clk);
        check(o_timer4_event, 1'b0);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        bus(1'b0, 8'h17, 8'h00, q);
        check(q, 8'h3F);
        bus(1'b0, 8'h16, 8'h00, q);
        check(q, 8'h00);
        bus(1'b0, 8'h18, 8'h00, q);
        check(q, 8'h00);
        bus(1'b0, 8'h40, 8'h00, q);
        check(q, 8'h00);
        bus(1'b1, 8'h02, 8'h10, q);
        for (int m = 0; m < 8; m++)
        begin
            bus(1'b1, 8'h03, m[2] ? 8'h0C : 8'h00, q);
            bus(1'b1, 8'h14, m[2] ? 8'h0F : 8'h00, q);
            bus(1'b1, 8'h0C, m[2] ? 8'hFF : 8'h00, q);
            bus(1'b1, 8'h13, m[2] ? 8'hFF : 8'h00, q);
            bus(1'b1, 8'h18, m[2] ? 8'hFF : 8'h00, q);
            bus(1'b1, 8'h0A, {m[1:0], 6'h00}, q);
            bus(1'b1, 8'h11, {m[1:0], 6'h00}, q);
            bus(1'b1, 8'h16, {m[1:0], 6'h00}, q);
            repeat (3) @(posedge i_clk);
            check(o_port_a_pin_four, pin_exp(m[2], m[0], m[1]));
            check(o_port_a_pin_two, pin_exp(m[2], m[0], m[1]));
            check(o_port_b_pin_three, pin_exp(m[2], m[0], m[1]));
        end
        bus(1'b1, 8'h03, 8'hFF, q);
        bus(1'b0, 8'h03, 8'h00, q);
        check(q, 8'h3C);
        bus(1'b0, 8'h0A, 8'h00, q);
        check(q, 8'hC0);
        bus(1'b0, 8'h11, 8'h00, q);
        check(q, 8'hC0);
        bus(1'b0, 8'h14, 8'h00, q);
        check(q, 8'h0F);
        mode_run(8'h07, 8'h05, 20, 8'h00, 8'h00);
        mode_run(8'h01, 8'h05, 0, 8'hFF, 8'h05);
        mode_run(8'h03, 8'h40, 0, 8'h40, 8'h05);
        inst_mode = 2'b01;
        for (int k = 0; k < 4; k++)
            span(8'h01, 8'(k), 8'h40 >> k);
        span(8'h01, 8'h08, 8'h80);
        for (int ce = 0; ce < 2; ce++)
        begin
            arm(8'h01, ce ? 8'h38 : 8'h28, 8'hFF);
            repeat (5)
            begin
                repeat (4) @(posedge i_clk) i_external_count_pin <= 1'b1;
                repeat (4) @(posedge i_clk) i_external_count_pin <= 1'b0;
            end
            repeat (8) @(posedge i_clk) i_external_count_pin <= 1'b1;
            take(v);
            check(8'hFF - v, ce ? 8'h05 : 8'h06);
            @(posedge i_clk) i_external_count_pin <= 1'b0;
        end
        inst_mode = 2'b00;
        @(posedge i_clk) i_hosc_en <= 1'b1;
        span(8'h09, 8'h28, 8'h80);
        end_sim();
    end

    // whole run is near 1550 cycles; this leaves a wide margin
    initial
    begin
        #60000;
        error_cnt++;
        end_sim();
    end
endmodule // down_timer_pwm_unit_test

/* File: verification/dtpu_top_checker.sv */
/*
 * Port-level assertions for dtpu_top, bound into every instance.
 * Assumes the register master never raises wr and rd together.
 */
`timescale 1ns/1ps
`include "dtpu_regs.svh"

module dtpu_top_checker (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // observed ports
    input wire dtpu_pkg::dtpu_bus_t i_bus,
    input wire logic [`DTPU_DW-1:0] o_rdata,
    input wire dtpu_pkg::dtpu_pin_t o_port_a_pin_four,
    input wire dtpu_pkg::dtpu_pin_t o_port_b_pin_five,
    input wire dtpu_pkg::dtpu_pin_t o_port_a_pin_two,
    input wire dtpu_pkg::dtpu_pin_t o_port_a_pin_seven,
    input wire dtpu_pkg::dtpu_pin_t o_port_b_pin_three,
    input wire logic o_timer4_event
);
    default clocking dcb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    chk_rdata_idle:
    assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00) else $error("read data outside its slot");
    chk_p2_pin_owner:
    assert property (i_bus.wr && i_bus.addr == 8'h0A |-> ##2 o_port_a_pin_four.sel == $past(i_bus.wdata[7], 2))
        else $error("channel two pin owner wrong");
    chk_p3_pin_owner:
    assert property (i_bus.wr && i_bus.addr == 8'h11 |-> ##2 o_port_a_pin_two.sel == $past(i_bus.wdata[7], 2))
        else $error("channel three pin owner wrong");
    chk_p4_pin_owner:
    assert property (i_bus.wr && i_bus.addr == 8'h16 |-> ##2 o_port_b_pin_three.sel == $past(i_bus.wdata[7], 2))
        else $error("channel four pin owner wrong");
    chk_p2_pin_pair:
    assert property (o_port_a_pin_four == o_port_b_pin_five) else $error("channel two pins differ");
    chk_p3_pin_pair:
    assert property (o_port_a_pin_two == o_port_a_pin_seven) else $error("channel three pins differ");
    chk_count_load_read:
    assert property (i_bus.wr && i_bus.addr == 8'h15 ##1 i_bus.rd && i_bus.addr == 8'h15
        |=> o_rdata == $past(i_bus.wdata, 2)) else $error("count readback differs from load");
    chk_flag_hold:
    assert property (o_timer4_event && !(i_bus.wr && i_bus.addr == 8'h20 && i_bus.wdata[0]) |=> o_timer4_event)
        else $error("event flag dropped");

    cov_flag_rise: cover property ($rose(o_timer4_event));
    cov_load_read: cover property (i_bus.wr && i_bus.addr == 8'h15 ##1 i_bus.rd);
    cov_p4_active: cover property (o_port_b_pin_three.sel && o_port_b_pin_three.level);
endmodule // dtpu_top_checker

bind dtpu_top dtpu_top_checker chk_u (.i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
    .o_port_a_pin_four(o_port_a_pin_four), .o_port_b_pin_five(o_port_b_pin_five),
    .o_port_a_pin_two(o_port_a_pin_two), .o_port_a_pin_seven(o_port_a_pin_seven),
    .o_port_b_pin_three(o_port_b_pin_three), .o_timer4_event(o_timer4_event));
